// ===== src/hdpc_regs.svh
// Register map, field positions, reset values and timing counts of the power control block
`ifndef HDPC_REGS_SVH
`define HDPC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define HDPC_REG_MASK_LOW        8'h01
`define HDPC_REG_MASK_HIGH       8'h02
`define HDPC_REG_HD_CTRL         8'h03
`define HDPC_REG_STATUS          8'h3F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HDPC_MASK_LOW_RST        8'h00
`define HDPC_MASK_HIGH_RST       8'h7F
`define HDPC_HD_CTRL_RST         8'hFF

// ----------------------------------------------------------------------------
// Mask bit positions
// ----------------------------------------------------------------------------
`define HDPC_BIT_PLL             7
`define HDPC_BIT_TX_CONV         6
`define HDPC_BIT_TX_DIGITAL      5
`define HDPC_BIT_REF             4
`define HDPC_BIT_CONV_CML        3
`define HDPC_BIT_ADC             2
`define HDPC_BIT_GAIN_BIAS       1
`define HDPC_BIT_RX_GAIN         0
`define HDPC_FAST_BLOCKS         8'h65
`define HDPC_RX_FAST_BLOCKS      8'h05

// ----------------------------------------------------------------------------
// Half-duplex control fields
// ----------------------------------------------------------------------------
`define HDPC_DELAY_MSB           7
`define HDPC_DELAY_LSB           3
`define HDPC_BIT_RX_SRC          2
`define HDPC_BIT_TX_FAST_EN      1
`define HDPC_BIT_RX_FAST_EN      0
`define HDPC_FLUSH_WCLKS         6'h21

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HDPC_CLK_PERIOD_NS       20
`define HDPC_FAST_OFF_NS         100
`define HDPC_TX_UP_NS            500
`define HDPC_RX_UP_NS            2000
`define HDPC_FAST_OFF_CYC        (`HDPC_FAST_OFF_NS / `HDPC_CLK_PERIOD_NS)
`define HDPC_TX_UP_CYC           (`HDPC_TX_UP_NS / `HDPC_CLK_PERIOD_NS)
`define HDPC_RX_UP_CYC           (`HDPC_RX_UP_NS / `HDPC_CLK_PERIOD_NS)

`endif

// ===== src/hdpc_pkg.sv
// Types shared by the power control block
package hdpc_pkg;

  typedef enum logic [1:0] {
    HDPC_TX_ON,
    HDPC_TX_DRAIN,
    HDPC_TX_OFF
  } hdpc_tx_state_e;

  typedef logic [7:0] hdpc_byte_t;

endpackage

// ===== src/hdpc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hdpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Level moves only once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          level_out[i] <= 1'b0;
        end else if (stage2_r[i] == stage3_r[i]) begin
          level_out[i] <= stage3_r[i];
        end
      end
    end
  endgenerate

endmodule

// ===== src/hdpc_top.sv
// Power-down mask selection and half-duplex burst power sequencing
`timescale 1ns/1ps
`include "hdpc_regs.svh"
module hdpc_top
  import hdpc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       full_duplex_mode_in,
  input  wire logic       power_mask_select_pin_in,
  input  wire logic       transmit_burst_enable_in,
  input  wire logic       receive_burst_enable_in,
  input  wire logic       transmit_quiet_pin_in,
  input  wire logic       transmit_word_clock_in,
  output logic      [7:0] block_power_down_out,
  output logic            line_amp_power_down_out,
  output logic            interp_filter_enable_out,
  output logic            interp_flush_out
);

  localparam int FAST_OFF_CYC = `HDPC_FAST_OFF_CYC;
  localparam int TX_UP_CYC    = `HDPC_TX_UP_CYC;
  localparam int RX_UP_CYC    = `HDPC_RX_UP_CYC;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [5:0] pin_lvl;
  logic       full_lvl;
  logic       sel_lvl;
  logic       transmit_burst_enable_lvl;
  logic       receive_burst_enable_lvl;
  logic       quiet_lvl;
  logic       wclk_lvl;

  hdpc_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    ({full_duplex_mode_in, power_mask_select_pin_in, transmit_burst_enable_in,
                 receive_burst_enable_in, transmit_quiet_pin_in, transmit_word_clock_in}),
    .level_out (pin_lvl)
  );

  assign full_lvl  = pin_lvl[5];
  assign sel_lvl   = pin_lvl[4];
  assign transmit_burst_enable_lvl  = pin_lvl[3];
  assign receive_burst_enable_lvl  = pin_lvl[2];
  assign quiet_lvl = pin_lvl[1];
  assign wclk_lvl  = pin_lvl[0];

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  hdpc_byte_t mask_low_r;
  hdpc_byte_t mask_high_r;
  hdpc_byte_t hd_ctrl_r;
  hdpc_byte_t status_w;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_low_r  <= `HDPC_MASK_LOW_RST;
      mask_high_r <= `HDPC_MASK_HIGH_RST;
      hd_ctrl_r   <= `HDPC_HD_CTRL_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `HDPC_REG_MASK_LOW) begin
        mask_low_r <= reg_wdata_in;
      end
      if (reg_addr_in == `HDPC_REG_MASK_HIGH) begin
        mask_high_r <= reg_wdata_in;
      end
      if (reg_addr_in == `HDPC_REG_HD_CTRL) begin
        hd_ctrl_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `HDPC_REG_MASK_LOW:  reg_rdata_out <= mask_low_r;
        `HDPC_REG_MASK_HIGH: reg_rdata_out <= mask_high_r;
        `HDPC_REG_HD_CTRL:   reg_rdata_out <= hd_ctrl_r;
        `HDPC_REG_STATUS:    reg_rdata_out <= status_w;
        default:             reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------------
  logic [4:0] tx_delay;
  logic       rx_via_transmit_burst_enable;
  logic       tx_fast_en;
  logic       rx_fast_en;
  logic       hd_active;

  assign tx_delay    = hd_ctrl_r[`HDPC_DELAY_MSB:`HDPC_DELAY_LSB];
  assign rx_via_transmit_burst_enable = hd_ctrl_r[`HDPC_BIT_RX_SRC];
  assign tx_fast_en  = hd_ctrl_r[`HDPC_BIT_TX_FAST_EN];
  assign rx_fast_en  = hd_ctrl_r[`HDPC_BIT_RX_FAST_EN];
  assign hd_active   = !full_lvl;

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  logic transmit_burst_enable_prev_r;
  logic wclk_prev_r;
  logic transmit_burst_enable_fall;
  logic transmit_burst_enable_rise;
  logic wclk_edge;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      transmit_burst_enable_prev_r <= 1'b0;
      wclk_prev_r <= 1'b0;
    end else begin
      transmit_burst_enable_prev_r <= transmit_burst_enable_lvl;
      wclk_prev_r <= wclk_lvl;
    end
  end

  assign transmit_burst_enable_fall = transmit_burst_enable_prev_r && !transmit_burst_enable_lvl;
  assign transmit_burst_enable_rise = !transmit_burst_enable_prev_r && transmit_burst_enable_lvl;
  assign wclk_edge = wclk_lvl && !wclk_prev_r;

  // --------------------------------------------------------------------------
  // Transmit power-down sequencer
  // --------------------------------------------------------------------------
  hdpc_tx_state_e tx_state_r;
  logic [5:0]     wclk_cnt_r;
  logic           tx_amp_off;
  logic           tx_dig_off;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_state_r <= HDPC_TX_OFF;
    end else begin
      unique case (tx_state_r)
        HDPC_TX_ON: begin
          if (transmit_burst_enable_fall) begin
            tx_state_r <= HDPC_TX_DRAIN;
          end
        end
        HDPC_TX_DRAIN: begin
          if (transmit_burst_enable_rise) begin
            tx_state_r <= HDPC_TX_ON;
          end else if (wclk_cnt_r == `HDPC_FLUSH_WCLKS) begin
            tx_state_r <= HDPC_TX_OFF;
          end
        end
        HDPC_TX_OFF: begin
          if (transmit_burst_enable_rise) begin
            tx_state_r <= HDPC_TX_ON;
          end
        end
      endcase
    end
  end

  // Word clocks since the fall of the transmit enable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wclk_cnt_r <= 6'h00;
    end else if (tx_state_r != HDPC_TX_DRAIN) begin
      wclk_cnt_r <= 6'h00;
    end else if (wclk_edge && wclk_cnt_r != `HDPC_FLUSH_WCLKS) begin
      wclk_cnt_r <= wclk_cnt_r + 6'h01;
    end
  end

  // Amplifier drops at delay expiry, filter logic only after the flush
  assign tx_amp_off = (tx_state_r == HDPC_TX_OFF) ||
                      (tx_state_r == HDPC_TX_DRAIN && wclk_cnt_r >= {1'b0, tx_delay});
  assign tx_dig_off = (tx_state_r == HDPC_TX_OFF);

  // --------------------------------------------------------------------------
  // Receive power source
  // --------------------------------------------------------------------------
  logic rx_off;

  assign rx_off = rx_via_transmit_burst_enable ? transmit_burst_enable_lvl : !receive_burst_enable_lvl;

  // --------------------------------------------------------------------------
  // Power-down outputs
  // --------------------------------------------------------------------------
  hdpc_byte_t base_pd;
  hdpc_byte_t pd_nxt;
  logic       amp_pd_nxt;
  logic       filter_en_nxt;
  logic       flush_nxt;
  logic       quiet_act;

  assign base_pd   = sel_lvl ? mask_high_r : mask_low_r;
  assign quiet_act = full_lvl && !quiet_lvl;

  always_comb begin
    pd_nxt = base_pd;
    if (hd_active && tx_fast_en && tx_dig_off) begin
      pd_nxt[`HDPC_BIT_TX_DIGITAL] = 1'b1;
    end
    if (hd_active && rx_fast_en && rx_off) begin
      pd_nxt = pd_nxt | `HDPC_RX_FAST_BLOCKS;
    end
  end

  // Converter bit is left to the mask; only the amplifier follows bursts
  assign amp_pd_nxt    = base_pd[`HDPC_BIT_TX_CONV] || quiet_act ||
                         (hd_active && tx_fast_en && tx_amp_off);
  assign filter_en_nxt = !quiet_act && !pd_nxt[`HDPC_BIT_TX_DIGITAL];
  assign flush_nxt     = hd_active && tx_fast_en && tx_state_r == HDPC_TX_DRAIN;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      block_power_down_out     <= `HDPC_MASK_LOW_RST;
      line_amp_power_down_out  <= 1'b0;
      interp_filter_enable_out <= 1'b1;
      interp_flush_out         <= 1'b0;
    end else begin
      block_power_down_out     <= pd_nxt;
      line_amp_power_down_out  <= amp_pd_nxt;
      interp_filter_enable_out <= filter_en_nxt;
      interp_flush_out         <= flush_nxt;
    end
  end

  assign status_w = {tx_amp_off, tx_dig_off, rx_off, wclk_cnt_r[4:0] == 5'h00 ? 1'b0 : 1'b1,
                     full_lvl, sel_lvl, transmit_burst_enable_lvl, receive_burst_enable_lvl};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_tx_fall;
    $fell(transmit_burst_enable_lvl) && tx_state_r == HDPC_TX_ON;
  endsequence

  sequence s_tx_rise;
    $rose(transmit_burst_enable_lvl) && tx_state_r != HDPC_TX_ON;
  endsequence

  AST_MASK_SELECT: assert property (full_lvl |=>
      block_power_down_out == ($past(sel_lvl) ? $past(mask_high_r) : $past(mask_low_r)))
    else $error("selected mask not applied");

  AST_PIN_LATENCY: assert property ($rose(power_mask_select_pin_in) && full_lvl &&
      $stable(mask_high_r) ##1 $stable(power_mask_select_pin_in) [*4]
      |-> ##[1:FAST_OFF_CYC] block_power_down_out == mask_high_r)
    else $error("select pin change too slow");

  AST_RESET_MASKS: assert property ($past(rst_in) |-> mask_low_r == `HDPC_MASK_LOW_RST &&
      mask_high_r == `HDPC_MASK_HIGH_RST && hd_ctrl_r == `HDPC_HD_CTRL_RST)
    else $error("bad register reset values");

  AST_SLOW_BLOCKS: assert property (1'b1 |=>
      (block_power_down_out & ~`HDPC_FAST_BLOCKS) == ($past(base_pd) & ~`HDPC_FAST_BLOCKS))
    else $error("slow block switched by burst");

  AST_QUIET: assert property (full_lvl && !quiet_lvl |=>
      line_amp_power_down_out && !interp_filter_enable_out)
    else $error("quiet pin did not silence amplifier");

  AST_TX_DELAY: assert property (s_tx_fall |=> tx_state_r == HDPC_TX_DRAIN &&
      !tx_dig_off)
    else $error("transmit fall did not start delay");

  AST_TX_EXPIRY: assert property (hd_active && tx_fast_en && tx_state_r == HDPC_TX_DRAIN &&
      wclk_cnt_r >= {1'b0, tx_delay} |=> line_amp_power_down_out)
    else $error("amplifier on after delay expiry");

  AST_FLUSH: assert property ((hd_active && tx_fast_en) ##0 s_tx_fall |=> ##1 interp_flush_out)
    else $error("flush not started after transmit fall");

  AST_TX_UP: assert property (s_tx_rise |=> tx_state_r == HDPC_TX_ON ##1
      wclk_cnt_r == 6'h00)
    else $error("transmit rise did not power up");

  AST_RX_POWER: assert property (hd_active && rx_fast_en |=>
      block_power_down_out[`HDPC_BIT_ADC] == ($past(base_pd[`HDPC_BIT_ADC]) | $past(rx_off)))
    else $error("receive power wrong");

  AST_FULL_IGNORES: assert property (full_lvl |=> !interp_flush_out)
    else $error("half-duplex control active in full duplex");

  AST_TX_UP_TIME: assert property (hd_active && $rose(transmit_burst_enable_lvl) && !base_pd[`HDPC_BIT_TX_CONV] |->
      ##[1:TX_UP_CYC] !line_amp_power_down_out)
    else $error("amplifier not powered after transmit rise");

  AST_RX_UP_TIME: assert property (hd_active && rx_fast_en && rx_via_transmit_burst_enable && $fell(transmit_burst_enable_lvl) &&
      !base_pd[`HDPC_BIT_ADC] |-> ##[1:RX_UP_CYC] !block_power_down_out[`HDPC_BIT_ADC])
    else $error("receive path not powered after transmit fall");

endmodule

// ===== verif/hdpc_backend_model.sv
// Back-end model that drives the burst enables and the transmit word clock
`timescale 1ns/1ps
module hdpc_backend_model (
  input  wire logic clk_in,
  output logic      transmit_burst_enable_out,
  output logic      receive_burst_enable_out,
  output logic      transmit_word_clock_out
);
  logic [1:0] div_r;
  int         tail_r;

  initial begin
    transmit_burst_enable_out = 1'b0;
    receive_burst_enable_out  = 1'b0;
    transmit_word_clock_out   = 1'b0;
    div_r                     = 2'h0;
    tail_r                    = 0;
  end

  // ----------------------------------------------------------------------------
  // Word clock: period of 8 system clocks, runs in a burst and 40 periods after
  // ----------------------------------------------------------------------------
  always @(posedge clk_in) begin
    #2;
    if (transmit_burst_enable_out || tail_r > 0) begin
      div_r = div_r + 2'h1;
      if (div_r == 2'h0) begin
        transmit_word_clock_out = ~transmit_word_clock_out;
        if (!transmit_word_clock_out && !transmit_burst_enable_out) tail_r = tail_r - 1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Burst enable drivers
  // ----------------------------------------------------------------------------
  task automatic drive_tx(input logic v);
    @(posedge clk_in);
    #2;
    if (transmit_burst_enable_out && !v) tail_r = 40;
    transmit_burst_enable_out = v;
  endtask

  task automatic drive_rx(input logic v);
    @(posedge clk_in);
    #2;
    receive_burst_enable_out = v;
  endtask
endmodule

// ===== verif/hdpc_top_tb_top.sv
// Self-checking testbench of the power control block
`timescale 1ns/1ps
module hdpc_top_tb_top;
  logic       clk_in;
  logic       rst_in;
  logic       reg_wr;
  logic       reg_rd;
  logic       fd_mode;
  logic       sel_pin;
  logic       quiet_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] pd;
  logic       tx_en;
  logic       rx_en;
  logic       wclk;
  logic       amp_pd;
  logic       filt_en;
  logic       flush;
  int         mismatches;
  int         cmp_count;

  hdpc_backend_model be (
    .clk_in                    (clk_in),
    .transmit_burst_enable_out (tx_en),
    .receive_burst_enable_out  (rx_en),
    .transmit_word_clock_out   (wclk)
  );

  hdpc_top dut (
    .clk_in                   (clk_in),
    .rst_in                   (rst_in),
    .reg_addr_in              (reg_addr),
    .reg_wdata_in             (reg_wdata),
    .reg_wr_in                (reg_wr),
    .reg_rd_in                (reg_rd),
    .reg_rdata_out            (reg_rdata),
    .full_duplex_mode_in      (fd_mode),
    .power_mask_select_pin_in (sel_pin),
    .transmit_burst_enable_in (tx_en),
    .receive_burst_enable_in  (rx_en),
    .transmit_quiet_pin_in    (quiet_n),
    .transmit_word_clock_in   (wclk),
    .block_power_down_out     (pd),
    .line_amp_power_down_out  (amp_pd),
    .interp_filter_enable_out (filt_en),
    .interp_flush_out         (flush)
  );

  // ----------------------------------------------------------------------------
  // Clock and common tasks
  // ----------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #2;
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(posedge clk_in);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #2;
    reg_addr = a; reg_rd = 1'b1;
    @(posedge clk_in);
    #2;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_in);
    #2;
  endtask

  task automatic wait_flush_end();
    int n;
    n = 0;
    while (flush !== 1'b0 && n < 600) begin
      @(posedge clk_in);
      n++;
    end
    #2;
    check("flush ends", {7'h0, flush}, 8'h00);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic sc_reset_regs();
    logic [7:0] d;
    rd(8'h01, d); check("mask low reset", d, 8'h00);
    rd(8'h02, d); check("mask high reset", d, 8'h7F);
    rd(8'h03, d); check("hd ctrl reset", d, 8'hFF);
    wr(8'h10, 8'hAA);
    rd(8'h10, d); check("unmapped read", d, 8'h00);
  endtask

  task automatic sc_tx_burst();
    be.drive_tx(1'b1); settle();
    check("pd in tx burst", pd, 8'h05);
    check("amp in tx burst", {7'h0, amp_pd}, 8'h00);
    repeat (20) @(posedge clk_in);
    be.drive_tx(1'b0); settle();
    check("pd rx burst", pd, 8'h00);
    check("flush running", {7'h0, flush}, 8'h01);
    check("amp before delay", {7'h0, amp_pd}, 8'h00);
    wait_flush_end(); settle();
    check("pd tx off", pd, 8'h20);
    check("amp tx off", {7'h0, amp_pd}, 8'h01);
    check("filter off", {7'h0, filt_en}, 8'h00);
  endtask

  task automatic sc_zero_delay();
    wr(8'h03, 8'h07);
    be.drive_tx(1'b1); settle();
    be.drive_tx(1'b0); settle();
    check("amp delay zero", {7'h0, amp_pd}, 8'h01);
    check("flush still on", {7'h0, flush}, 8'h01);
    wait_flush_end();
  endtask

  task automatic sc_cancel();
    wr(8'h03, 8'hFF);
    be.drive_tx(1'b1); settle();
    be.drive_tx(1'b0);
    repeat (40) @(posedge clk_in);
    be.drive_tx(1'b1);
    repeat (300) @(posedge clk_in);
    #2;
    check("amp after cancel", {7'h0, amp_pd}, 8'h00);
    check("pd after cancel", pd, 8'h05);
  endtask

  task automatic sc_rx_source();
    wr(8'h03, 8'hFB);
    be.drive_rx(1'b1); settle();
    check("pd rx enable high", pd, 8'h00);
    be.drive_rx(1'b0); settle();
    check("pd rx enable low", pd, 8'h05);
  endtask

  task automatic sc_fast_off();
    wr(8'h03, 8'h04);
    be.drive_tx(1'b0);
    repeat (400) @(posedge clk_in);
    #2;
    check("pd fast off", pd, 8'h00);
    check("amp fast off", {7'h0, amp_pd}, 8'h00);
  endtask

  task automatic sc_master_pin();
    wr(8'h02, 8'h18);
    sel_pin = 1'b1; settle();
    check("pd select high hd", pd, 8'h18);
    sel_pin = 1'b0; settle();
    check("pd select low hd", pd, 8'h00);
  endtask

  task automatic sc_full_duplex();
    logic [7:0] d;
    fd_mode = 1'b1;
    wr(8'h01, 8'h60);
    wr(8'h02, 8'h05);
    rd(8'h01, d); check("mask low rw", d, 8'h60);
    wr(8'h03, 8'hFF); settle();
    check("pd low mask", pd, 8'h60);
    check("amp low mask", {7'h0, amp_pd}, 8'h01);
    sel_pin = 1'b1; settle();
    check("pd high mask", pd, 8'h05);
    check("amp high mask", {7'h0, amp_pd}, 8'h00);
    be.drive_tx(1'b1); settle();
    be.drive_tx(1'b0);
    repeat (400) @(posedge clk_in);
    #2;
    check("pd fd ignores ctrl", pd, 8'h05);
    check("amp fd ignores ctrl", {7'h0, amp_pd}, 8'h00);
    wr(8'h02, 8'h00);
    quiet_n = 1'b0; settle();
    check("amp quiet", {7'h0, amp_pd}, 8'h01);
    check("filter quiet", {7'h0, filt_en}, 8'h00);
    check("pd quiet", pd, 8'h00);
    quiet_n = 1'b1; settle();
    check("amp quiet off", {7'h0, amp_pd}, 8'h00);
    rd(8'h3F, d); check("status", d, 8'hCC);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    mismatches = 0; cmp_count = 0;
    rst_in = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    fd_mode = 1'b0; sel_pin = 1'b0; quiet_n = 1'b1;
    repeat (2) @(posedge clk_in);
    #2;
    rst_in = 1'b0;
    sc_reset_regs();
    settle();
    sc_tx_burst();
    sc_zero_delay();
    sc_cancel();
    sc_rx_source();
    sc_fast_off();
    sc_master_pin();
    sc_full_duplex();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    summarize();
  end
endmodule
